/* File: logic/decode_pkg.sv */
// Constants and types shared by the opcode decoder and its address former
`default_nettype none
package decode_pkg;
  localparam int OPC_W  = 8;
  localparam int NIB_W  = 4;
  localparam int ADDR_W = 16;
  localparam int CYC_W  = 4;
  localparam int LEN_W  = 2;
  localparam int BIT_W  = 3;

  localparam logic [OPC_W-1:0] BYTE_ZERO = 8'h00;

  // Opcodes with their own behaviour
  localparam logic [OPC_W-1:0] OPC_COPY_INDEX_TO_ACC = 8'h9F;
  localparam logic [OPC_W-1:0] OPC_WAIT_CLOCK        = 8'h8F;
  localparam logic [OPC_W-1:0] OPC_HALT_OSC          = 8'h8E;
  localparam logic [OPC_W-1:0] OPC_RETURN_FROM_TRAP  = 8'h80;
  localparam logic [OPC_W-1:0] OPC_RETURN_SUB        = 8'h81;
  localparam logic [OPC_W-1:0] OPC_SOFT_TRAP         = 8'h83;
  localparam logic [OPC_W-1:0] OPC_PRODUCT           = 8'h42;
  localparam logic [OPC_W-1:0] OPC_BRANCH_TO_SUB     = 8'hAD;

  // Upper nibbles: group and addressing mode
  localparam logic [NIB_W-1:0] NIB_BIT_BRANCH = 4'h0;
  localparam logic [NIB_W-1:0] NIB_BIT_MODIFY = 4'h1;
  localparam logic [NIB_W-1:0] NIB_BRANCH     = 4'h2;
  localparam logic [NIB_W-1:0] NIB_RMW_DIR    = 4'h3;
  localparam logic [NIB_W-1:0] NIB_RMW_ACC    = 4'h4;
  localparam logic [NIB_W-1:0] NIB_RMW_IDX    = 4'h5;
  localparam logic [NIB_W-1:0] NIB_RMW_XB     = 4'h6;
  localparam logic [NIB_W-1:0] NIB_RMW_XP     = 4'h7;
  localparam logic [NIB_W-1:0] NIB_CTRL_STACK = 4'h8;
  localparam logic [NIB_W-1:0] NIB_CTRL_REG   = 4'h9;
  localparam logic [NIB_W-1:0] NIB_RM_LIT     = 4'hA;
  localparam logic [NIB_W-1:0] NIB_RM_DIR     = 4'hB;
  localparam logic [NIB_W-1:0] NIB_RM_LONG    = 4'hC;
  localparam logic [NIB_W-1:0] NIB_RM_XW      = 4'hD;
  localparam logic [NIB_W-1:0] NIB_RM_XB      = 4'hE;
  localparam logic [NIB_W-1:0] NIB_RM_XP      = 4'hF;

  // Lower nibbles with special effects
  localparam logic [NIB_W-1:0] LO_CPX = 4'h3;
  localparam logic [NIB_W-1:0] LO_STA = 4'h7;
  localparam logic [NIB_W-1:0] LO_CLC = 4'h8;
  localparam logic [NIB_W-1:0] LO_ADC = 4'h9;
  localparam logic [NIB_W-1:0] LO_SEC = 4'h9;
  localparam logic [NIB_W-1:0] LO_DEC = 4'hA;
  localparam logic [NIB_W-1:0] LO_CLI = 4'hA;
  localparam logic [NIB_W-1:0] LO_ADD = 4'hB;
  localparam logic [NIB_W-1:0] LO_SEI = 4'hB;
  localparam logic [NIB_W-1:0] LO_INC = 4'hC;
  localparam logic [NIB_W-1:0] LO_JMP = 4'hC;
  localparam logic [NIB_W-1:0] LO_TST = 4'hD;
  localparam logic [NIB_W-1:0] LO_JSR = 4'hD;
  localparam logic [NIB_W-1:0] LO_CLR = 4'hF;
  localparam logic [NIB_W-1:0] LO_STX = 4'hF;

  // Implemented or empty slots per lower nibble, one bit each
  localparam logic [15:0] RMW_HOLES   = 16'h4826;
  localparam logic [15:0] LIT_HOLES   = 16'h9080;
  localparam logic [15:0] STACK_USED  = 16'hC00B;
  localparam logic [15:0] REG_USED    = 16'hBF80;

  // Instruction lengths in bytes
  localparam logic [LEN_W-1:0] LEN_ONE   = 2'h1;
  localparam logic [LEN_W-1:0] LEN_TWO   = 2'h2;
  localparam logic [LEN_W-1:0] LEN_THREE = 2'h3;

  // Cycle counts
  localparam logic [CYC_W-1:0] CYC_ZERO        = 4'h0;
  localparam logic [CYC_W-1:0] CYC_ONE         = 4'h1;
  localparam logic [CYC_W-1:0] CYC_JSR_EXTRA   = 4'h2;
  localparam logic [CYC_W-1:0] CYC_SHORT       = 4'h2;
  localparam logic [CYC_W-1:0] CYC_BIT_OP      = 4'h5;
  localparam logic [CYC_W-1:0] CYC_REL         = 4'h3;
  localparam logic [CYC_W-1:0] CYC_RMW_DIR     = 4'h5;
  localparam logic [CYC_W-1:0] CYC_RMW_REG     = 4'h3;
  localparam logic [CYC_W-1:0] CYC_RMW_XB      = 4'h6;
  localparam logic [CYC_W-1:0] CYC_RMW_XP      = 4'h5;
  localparam logic [CYC_W-1:0] CYC_PRODUCT     = 4'hB;
  localparam logic [CYC_W-1:0] CYC_RETURN_TRAP = 4'h9;
  localparam logic [CYC_W-1:0] CYC_RETURN_SUB  = 4'h6;
  localparam logic [CYC_W-1:0] CYC_SOFT_TRAP   = 4'hA;
  localparam logic [CYC_W-1:0] CYC_BRANCH_SUB  = 4'h6;
  localparam logic [CYC_W-1:0] CYC_RM_LIT      = 4'h2;
  localparam logic [CYC_W-1:0] CYC_RM_DIR      = 4'h3;
  localparam logic [CYC_W-1:0] CYC_RM_LONG     = 4'h4;
  localparam logic [CYC_W-1:0] CYC_RM_XW       = 4'h5;
  localparam logic [CYC_W-1:0] CYC_RM_XB       = 4'h4;
  localparam logic [CYC_W-1:0] CYC_RM_XP       = 4'h3;

  typedef enum logic [2:0] {
    NO_OPERAND_MODE        = 3'b000,
    LITERAL_OPERAND_MODE   = 3'b001,
    DIRECT_MODE            = 3'b010,
    LONG_ABSOLUTE_MODE     = 3'b011,
    INDEX_WORD_OFFSET_MODE = 3'b100,
    INDEX_BYTE_OFFSET_MODE = 3'b101,
    INDEX_PLAIN_MODE       = 3'b110,
    RELATIVE_MODE          = 3'b111
  } mode_t;

  typedef enum logic [2:0] {
    GRP_BIT_BRANCH = 3'b000,
    GRP_BIT_MODIFY = 3'b001,
    GRP_BRANCH     = 3'b010,
    GRP_RMW        = 3'b011,
    GRP_CONTROL    = 3'b100,
    GRP_REG_MEM    = 3'b101
  } group_t;

  // Flags of the flag_register that an instruction may change
  typedef struct packed {
    logic h;
    logic i;
    logic n;
    logic z;
    logic c;
  } flag_fx_t;

  typedef struct packed {
    logic             valid;
    logic             unimpl;
    group_t           group;
    mode_t            mode;
    logic [NIB_W-1:0] op;
    logic [BIT_W-1:0] bit_num;
    logic             bit_one;
    logic [LEN_W-1:0] len;
    logic [CYC_W-1:0] cycles;
    flag_fx_t         fx;
    logic             halt_osc;
    logic             halt_clk;
    logic             copy_index_to_acc;
  } decode_t;

  function automatic logic [ADDR_W-1:0] sign_widen(
    input logic [OPC_W-1:0] b
  );
    sign_widen = {{(ADDR_W-OPC_W){b[OPC_W-1]}}, b};
  endfunction
endpackage
`default_nettype wire

/* File: logic/operand_former.sv */
// Effective address and branch target former for decoded operands
`timescale 1ns/1ns
`default_nettype none
module operand_former (
  // Decoded shape
  input  wire decode_pkg::mode_t          mode_in,
  input  wire logic                       bit_branch_in,
  // Operand bytes and registers
  input  wire logic [decode_pkg::OPC_W-1:0]  first_byte_in,
  input  wire logic [decode_pkg::OPC_W-1:0]  second_byte_in,
  input  wire logic [decode_pkg::OPC_W-1:0]  index_in,
  input  wire logic [decode_pkg::ADDR_W-1:0] pc_in,
  // Results
  output logic      [decode_pkg::ADDR_W-1:0] eff_addr_out,
  output logic      [decode_pkg::ADDR_W-1:0] target_out
);
  import decode_pkg::*;

  logic [ADDR_W-1:0] word_op;
  logic [ADDR_W-1:0] index_wide;
  logic [OPC_W-1:0]  offset;

  always_comb begin
    word_op    = {first_byte_in, second_byte_in};
    index_wide = {BYTE_ZERO, index_in};
    case (mode_in)
      LONG_ABSOLUTE_MODE:     eff_addr_out = word_op;
      INDEX_WORD_OFFSET_MODE: eff_addr_out = word_op + index_wide;
      INDEX_BYTE_OFFSET_MODE:
        eff_addr_out = {BYTE_ZERO, first_byte_in} + index_wide;
      INDEX_PLAIN_MODE:       eff_addr_out = index_wide;
      DIRECT_MODE:            eff_addr_out = {BYTE_ZERO, first_byte_in};
      default:                eff_addr_out = {ADDR_W{1'b0}};
    endcase
    // Bit tests carry the offset after the direct address byte
    offset     = bit_branch_in ? second_byte_in : first_byte_in;
    target_out = pc_in + sign_widen(offset);
  end
endmodule
`default_nettype wire

/* File: logic/opcode_decoder.sv */
// Opcode decoder: group, mode, length, cycles, flag effects and addresses
`timescale 1ns/1ns
`default_nettype none
module opcode_decoder (
  // Clock and reset
  input  wire logic                          sys_clk_in,
  input  wire logic                          nrst_in,
  // Instruction bytes from the fetch logic
  input  wire logic                          opcode_valid_in,
  input  wire logic [decode_pkg::OPC_W-1:0]  opcode_in,
  input  wire logic [decode_pkg::OPC_W-1:0]  first_byte_in,
  input  wire logic [decode_pkg::OPC_W-1:0]  second_byte_in,
  // Core state
  input  wire logic [decode_pkg::OPC_W-1:0]  index_in,
  input  wire logic [decode_pkg::ADDR_W-1:0] pc_next_in,
  input  wire logic                          branch_cond_in,
  // Decode results
  output decode_pkg::decode_t                decode_out,
  output logic      [decode_pkg::ADDR_W-1:0] eff_addr_out,
  output logic      [decode_pkg::ADDR_W-1:0] target_out,
  output logic                               take_branch_out
);
  import decode_pkg::*;

  decode_t           decode_reg;
  decode_t           decode_next;
  logic [ADDR_W-1:0] ea_reg;
  logic [ADDR_W-1:0] ea_next;
  logic [ADDR_W-1:0] target_reg;
  logic [ADDR_W-1:0] target_next;
  logic              take_reg;
  logic              take_next;
  logic [NIB_W-1:0]  hi;
  logic [NIB_W-1:0]  lo;

  function automatic logic [LEN_W-1:0] mode_len(input mode_t m);
    case (m)
      NO_OPERAND_MODE, INDEX_PLAIN_MODE:          mode_len = LEN_ONE;
      LONG_ABSOLUTE_MODE, INDEX_WORD_OFFSET_MODE: mode_len = LEN_THREE;
      default:                                    mode_len = LEN_TWO;
    endcase
  endfunction

  function automatic mode_t mode_of(input logic [NIB_W-1:0] n);
    case (n)
      NIB_RMW_DIR, NIB_RM_DIR: mode_of = DIRECT_MODE;
      NIB_RMW_XB, NIB_RM_XB:   mode_of = INDEX_BYTE_OFFSET_MODE;
      NIB_RMW_XP, NIB_RM_XP:   mode_of = INDEX_PLAIN_MODE;
      NIB_RM_LIT:              mode_of = LITERAL_OPERAND_MODE;
      NIB_RM_LONG:             mode_of = LONG_ABSOLUTE_MODE;
      NIB_RM_XW:               mode_of = INDEX_WORD_OFFSET_MODE;
      default:                 mode_of = NO_OPERAND_MODE;
    endcase
  endfunction

  always_comb begin
    hi                     = opcode_in[OPC_W-1:NIB_W];
    lo                     = opcode_in[NIB_W-1:0];
    decode_next            = '0;
    decode_next.valid      = opcode_valid_in;
    decode_next.op         = lo;
    decode_next.mode       = mode_of(hi);
    decode_next.len        = LEN_ONE;
    case (hi)
      NIB_BIT_BRANCH: begin
        decode_next.group   = GRP_BIT_BRANCH;
        decode_next.mode    = DIRECT_MODE;
        decode_next.bit_num = lo[NIB_W-1:1];
        decode_next.bit_one = ~lo[0];
        decode_next.len     = LEN_THREE;
        decode_next.cycles  = CYC_BIT_OP;
        decode_next.fx.c    = 1'b1;
      end
      NIB_BIT_MODIFY: begin
        decode_next.group   = GRP_BIT_MODIFY;
        decode_next.mode    = DIRECT_MODE;
        decode_next.bit_num = lo[NIB_W-1:1];
        decode_next.bit_one = ~lo[0];
        decode_next.len     = LEN_TWO;
        decode_next.cycles  = CYC_BIT_OP;
      end
      NIB_BRANCH: begin
        decode_next.group  = GRP_BRANCH;
        decode_next.mode   = RELATIVE_MODE;
        decode_next.len    = LEN_TWO;
        decode_next.cycles = CYC_REL;
      end
      NIB_RMW_DIR, NIB_RMW_ACC, NIB_RMW_IDX, NIB_RMW_XB, NIB_RMW_XP: begin
        decode_next.group = GRP_RMW;
        decode_next.len   = mode_len(decode_next.mode);
        case (hi)
          NIB_RMW_DIR: decode_next.cycles = CYC_RMW_DIR;
          NIB_RMW_XB:  decode_next.cycles = CYC_RMW_XB;
          NIB_RMW_XP:  decode_next.cycles = CYC_RMW_XP;
          default:     decode_next.cycles = CYC_RMW_REG;
        endcase
        // Only memory forms of the test save the write-back cycle
        if ((lo == LO_TST) && (decode_next.mode != NO_OPERAND_MODE)) begin
          decode_next.cycles = decode_next.cycles - CYC_ONE;
        end
        decode_next.fx.n = 1'b1;
        decode_next.fx.z = 1'b1;
        decode_next.fx.c = (lo != LO_DEC) && (lo != LO_INC)
                           && (lo != LO_TST) && (lo != LO_CLR);
        if (opcode_in == OPC_PRODUCT) begin
          decode_next.cycles = CYC_PRODUCT;
          decode_next.fx     = '{h: 1'b1, i: 1'b0, n: 1'b0, z: 1'b0,
                                 c: 1'b1};
        end else if (RMW_HOLES[lo]) begin
          decode_next.unimpl = 1'b1;
        end
      end
      NIB_CTRL_STACK: begin
        decode_next.group = GRP_CONTROL;
        case (opcode_in)
          OPC_RETURN_FROM_TRAP: begin
            decode_next.cycles = CYC_RETURN_TRAP;
            decode_next.fx     = '1;
          end
          OPC_RETURN_SUB: decode_next.cycles = CYC_RETURN_SUB;
          OPC_SOFT_TRAP: begin
            decode_next.cycles = CYC_SOFT_TRAP;
            decode_next.fx.i   = 1'b1;
          end
          OPC_HALT_OSC: begin
            decode_next.cycles   = CYC_SHORT;
            decode_next.fx.i     = 1'b1;
            decode_next.halt_osc = 1'b1;
          end
          OPC_WAIT_CLOCK: begin
            decode_next.cycles   = CYC_SHORT;
            decode_next.fx.i     = 1'b1;
            decode_next.halt_clk = 1'b1;
          end
          default: decode_next.unimpl = 1'b1;
        endcase
      end
      NIB_CTRL_REG: begin
        decode_next.group  = GRP_CONTROL;
        decode_next.cycles = CYC_SHORT;
        decode_next.fx.c   = (lo == LO_CLC) || (lo == LO_SEC);
        decode_next.fx.i   = (lo == LO_CLI) || (lo == LO_SEI);
        decode_next.copy_index_to_acc =
          (opcode_in == OPC_COPY_INDEX_TO_ACC);
        if (!REG_USED[lo]) begin
          decode_next.unimpl = 1'b1;
          decode_next.cycles = CYC_ZERO;
        end
      end
      default: begin
        decode_next.group = GRP_REG_MEM;
        decode_next.len   = mode_len(decode_next.mode);
        case (hi)
          NIB_RM_LIT:  decode_next.cycles = CYC_RM_LIT;
          NIB_RM_DIR:  decode_next.cycles = CYC_RM_DIR;
          NIB_RM_LONG: decode_next.cycles = CYC_RM_LONG;
          NIB_RM_XW:   decode_next.cycles = CYC_RM_XW;
          NIB_RM_XB:   decode_next.cycles = CYC_RM_XB;
          default:     decode_next.cycles = CYC_RM_XP;
        endcase
        if ((lo == LO_STA) || (lo == LO_STX)) begin
          decode_next.cycles = decode_next.cycles + CYC_ONE;
        end else if (lo == LO_JMP) begin
          decode_next.cycles = decode_next.cycles - CYC_ONE;
        end else if (lo == LO_JSR) begin
          decode_next.cycles = decode_next.cycles + CYC_JSR_EXTRA;
        end
        decode_next.fx.h = (lo == LO_ADC) || (lo == LO_ADD);
        decode_next.fx.n = (lo != LO_JMP) && (lo != LO_JSR);
        decode_next.fx.z = decode_next.fx.n;
        decode_next.fx.c = (lo <= LO_CPX) || decode_next.fx.h;
        if (opcode_in == OPC_BRANCH_TO_SUB) begin
          decode_next.group  = GRP_BRANCH;
          decode_next.mode   = RELATIVE_MODE;
          decode_next.len    = LEN_TWO;
          decode_next.cycles = CYC_BRANCH_SUB;
        end else if ((hi == NIB_RM_LIT) && LIT_HOLES[lo]) begin
          decode_next.unimpl = 1'b1;
          decode_next.mode   = NO_OPERAND_MODE;
        end
      end
    endcase
    // Empty slots are one inert byte, whatever row they sit in
    if (decode_next.unimpl) begin
      decode_next.fx     = '0;
      decode_next.len    = LEN_ONE;
      decode_next.cycles = CYC_ZERO;
    end
    // Bit tests and relative ops both branch only when the condition is set
    take_next = opcode_valid_in && !decode_next.unimpl
                && ((decode_next.mode == RELATIVE_MODE)
                    || (decode_next.group == GRP_BIT_BRANCH))
                && branch_cond_in;
  end

  operand_former u_former (
    .mode_in        (decode_next.mode),
    .bit_branch_in  (decode_next.group == GRP_BIT_BRANCH),
    .first_byte_in  (first_byte_in),
    .second_byte_in (second_byte_in),
    .index_in       (index_in),
    .pc_in          (pc_next_in),
    .eff_addr_out   (ea_next),
    .target_out     (target_next)
  );

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      decode_reg <= '0;
      ea_reg     <= '0;
      target_reg <= '0;
      take_reg   <= 1'b0;
    end else begin
      decode_reg <= decode_next;
      ea_reg     <= ea_next;
      target_reg <= target_next;
      take_reg   <= take_next;
    end
  end

  assign decode_out      = decode_reg;
  assign eff_addr_out    = ea_reg;
  assign target_out      = target_reg;
  assign take_branch_out = take_reg;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!nrst_in);

  AST_COPY_INDEX: assert property (
    opcode_valid_in && (opcode_in == OPC_COPY_INDEX_TO_ACC) |=>
      decode_out.copy_index_to_acc && (decode_out.cycles == CYC_SHORT)
      && (decode_out.len == LEN_ONE) && (decode_out.fx == '0)
      && (decode_out.mode == NO_OPERAND_MODE))
    else $error("copy index to accumulator decoded wrongly");

  AST_WAIT_CLOCK: assert property (
    (opcode_in == OPC_WAIT_CLOCK) |=>
      decode_out.halt_clk && !decode_out.halt_osc && decode_out.fx.i
      && !decode_out.fx.c && (decode_out.cycles == CYC_SHORT))
    else $error("wait opcode decoded wrongly");

  AST_NIBBLE_SPLIT: assert property (
    opcode_valid_in |=> decode_out.valid
      && (decode_out.op == $past(opcode_in[NIB_W-1:0])))
    else $error("lower nibble not carried to operation field");

  AST_BIT_TEST: assert property (
    (opcode_in[OPC_W-1:NIB_W] == NIB_BIT_BRANCH) |=>
      (decode_out.len == LEN_THREE) && (decode_out.cycles == CYC_BIT_OP)
      && (decode_out.bit_num == $past(opcode_in[NIB_W-1:1]))
      && (decode_out.bit_one == !$past(opcode_in[0])))
    else $error("bit test decode wrong");

  AST_BIT_TEST_BYTES: assert property (
    (opcode_in[OPC_W-1:NIB_W] == NIB_BIT_BRANCH) |=>
      (eff_addr_out == {BYTE_ZERO, $past(first_byte_in)})
      && (target_out == $past(pc_next_in)
                        + sign_widen($past(second_byte_in))))
    else $error("bit test operand bytes misused");

  AST_WORD_OFFSET: assert property (
    (opcode_in[OPC_W-1:NIB_W] == NIB_RM_XW) |=>
      (eff_addr_out == $past({first_byte_in, second_byte_in})
                       + {BYTE_ZERO, $past(index_in)}))
    else $error("word offset address wrong");

  AST_LONG_ABSOLUTE: assert property (
    (opcode_in[OPC_W-1:NIB_W] == NIB_RM_LONG) |=>
      (eff_addr_out == $past({first_byte_in, second_byte_in}))
      && (decode_out.len == LEN_THREE))
    else $error("long absolute address wrong");

  AST_BYTE_OFFSET: assert property (
    (opcode_in[OPC_W-1:NIB_W] == NIB_RM_XB) |=>
      (eff_addr_out == {BYTE_ZERO, $past(first_byte_in)}
                       + {BYTE_ZERO, $past(index_in)}))
    else $error("byte offset address wrong");

  AST_INDEX_PLAIN: assert property (
    (opcode_in[OPC_W-1:NIB_W] == NIB_RM_XP) |=>
      (eff_addr_out == {BYTE_ZERO, $past(index_in)})
      && (decode_out.len == LEN_ONE))
    else $error("plain indexed address wrong");

  AST_RELATIVE: assert property (
    opcode_valid_in && (opcode_in[OPC_W-1:NIB_W] == NIB_BRANCH) |=>
      (take_branch_out == $past(branch_cond_in))
      && (target_out == $past(pc_next_in)
                        + sign_widen($past(first_byte_in))))
    else $error("relative branch target or decision wrong");

  AST_MODE_LENGTH: assert property (
    (opcode_in[OPC_W-1:NIB_W] == NIB_RM_DIR) ##1
      (decode_out.mode == DIRECT_MODE) |-> (decode_out.len == LEN_TWO))
    else $error("register memory length wrong");

  AST_FIXED_CYCLES: assert property (
    (opcode_in == OPC_PRODUCT) |=> (decode_out.cycles == CYC_PRODUCT)
      && (decode_out.len == LEN_ONE) && !decode_out.unimpl)
    else $error("cycle count wrong");

  AST_STACK_CYCLES: assert property (
    (opcode_in == OPC_SOFT_TRAP) |=> (decode_out.cycles == CYC_SOFT_TRAP)
      && decode_out.fx.i && (decode_out.len == LEN_ONE))
    else $error("software trap cycles wrong");

  AST_HALT_OSC: assert property (
    (opcode_in == OPC_HALT_OSC) |=> decode_out.halt_osc
      && !decode_out.halt_clk && decode_out.fx.i
      && (decode_out.cycles == CYC_SHORT))
    else $error("oscillator halt decoded wrongly");

  AST_UNIMPL: assert property (
    decode_out.unimpl |-> (decode_out.fx == '0) && !take_branch_out
      && (decode_out.len == LEN_ONE))
    else $error("unimplemented opcode not held inert");

  COV_TAKEN_BIT_TEST: cover property (
    opcode_valid_in && (opcode_in[OPC_W-1:NIB_W] == NIB_BIT_BRANCH)
    ##1 take_branch_out);
  COV_WAIT: cover property (decode_out.halt_clk ##1 decode_out.valid);
  COV_UNIMPL: cover property (decode_out.valid && decode_out.unimpl);
  COV_WORD_OFFSET: cover property (
    decode_out.mode == INDEX_WORD_OFFSET_MODE);
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// Self-checking bench for the opcode decoder
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin samples_checked++; if ((e) !== (a)) begin \
  errors++; $display("mismatch %s expected %0h seen %0h", n, e, a); end end
module tb_top;
  import decode_pkg::*;
  logic          sys_clk_in;
  logic          nrst_in;
  logic          opcode_valid_in;
  logic [7:0]    opcode_in;
  logic [7:0]    first_byte_in;
  logic [7:0]    second_byte_in;
  logic [7:0]    index_in;
  logic [15:0]   pc_next_in;
  logic          branch_cond_in;
  decode_t       dec;
  logic [15:0]   eff_addr_out;
  logic [15:0]   target_out;
  logic          take_branch_out;
  int            errors;
  int            samples_checked;

  opcode_decoder uut (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
    .opcode_valid_in(opcode_valid_in), .opcode_in(opcode_in),
    .first_byte_in(first_byte_in), .second_byte_in(second_byte_in),
    .index_in(index_in), .pc_next_in(pc_next_in),
    .branch_cond_in(branch_cond_in), .decode_out(dec),
    .eff_addr_out(eff_addr_out), .target_out(target_out),
    .take_branch_out(take_branch_out));

  // One decode: inputs after an edge, outputs read just after the next
  task automatic step(input logic [7:0] op, input logic [7:0] f,
                      input logic [7:0] s, input logic cond);
    @(posedge sys_clk_in);
    #2;
    opcode_in = op;
    first_byte_in = f;
    second_byte_in = s;
    branch_cond_in = cond;
    opcode_valid_in = 1'b1;
    @(posedge sys_clk_in);
    #1;
  endtask

  task automatic t_special();
    step(OPC_COPY_INDEX_TO_ACC, 8'h00, 8'h00, 1'b0);
    `CHK("copy", 1'b1, dec.copy_index_to_acc);
    `CHK("valid", 1'b1, dec.valid);
    `CHK("mode", NO_OPERAND_MODE, dec.mode);
    `CHK("len", 2'h1, dec.len);
    `CHK("cyc", 4'h2, dec.cycles);
    `CHK("fx", 5'h00, dec.fx);
    step(8'h8F, 8'h00, 8'h00, 1'b0);
    `CHK("halt_clk", 2'h2, {dec.halt_clk, dec.halt_osc});
    `CHK("fx", 5'h08, dec.fx);
    `CHK("cyc", 4'h2, dec.cycles);
    step(8'h8E, 8'h00, 8'h00, 1'b0);
    `CHK("halt_osc", 2'h1, {dec.halt_clk, dec.halt_osc});
    `CHK("fx", 5'h08, dec.fx);
    `CHK("cyc", 4'h2, dec.cycles);
    $display("test special done");
  endtask

  task automatic t_bits();
    #1;
    pc_next_in = 16'h0103;
    step(8'h05, 8'h40, 8'hFE, 1'b1);
    `CHK("grp", GRP_BIT_BRANCH, dec.group);
    `CHK("bit", 4'h4, {dec.bit_num, dec.bit_one});
    `CHK("len", 2'h3, dec.len);
    `CHK("cyc", 4'h5, dec.cycles);
    `CHK("eff", 16'h0040, eff_addr_out);
    `CHK("tgt", 16'h0101, target_out);
    `CHK("take", 1'b1, take_branch_out);
    step(8'h0E, 8'h40, 8'h02, 1'b0);
    `CHK("bit", 4'hF, {dec.bit_num, dec.bit_one});
    `CHK("take", 1'b0, take_branch_out);
    $display("test bits done");
  endtask

  task automatic t_modes();
    mode_t       m[6] = '{LITERAL_OPERAND_MODE, DIRECT_MODE,
      LONG_ABSOLUTE_MODE, INDEX_WORD_OFFSET_MODE, INDEX_BYTE_OFFSET_MODE,
      INDEX_PLAIN_MODE};
    logic [1:0]  l[6] = '{2'h2, 2'h2, 2'h3, 2'h3, 2'h2, 2'h1};
    logic [3:0]  c[6] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h4, 4'h3};
    logic [15:0] e[6] = '{16'h0000, 16'h0092, 16'h9234, 16'h9324,
      16'h0182, 16'h00F0};
    #1;
    index_in = 8'hF0;
    for (int i = 0; i < 6; i++) begin
      step({4'(10 + i), 4'h2}, 8'h92, 8'h34, 1'b0);
      `CHK("grp", GRP_REG_MEM, dec.group);
      `CHK("op", 4'h2, dec.op);
      `CHK("mode", m[i], dec.mode);
      `CHK("len", l[i], dec.len);
      `CHK("cyc", c[i], dec.cycles);
      if (i > 0) `CHK("eff", e[i], eff_addr_out);
    end
    $display("test modes done");
  endtask

  task automatic t_branch();
    #1;
    pc_next_in = 16'h0200;
    step(8'h27, 8'h80, 8'h00, 1'b0);
    `CHK("mode", RELATIVE_MODE, dec.mode);
    `CHK("tgt", 16'h0180, target_out);
    `CHK("take", 1'b0, take_branch_out);
    step(8'hAD, 8'h10, 8'h00, 1'b1);
    `CHK("len_cyc", 6'h26, {dec.len, dec.cycles});
    `CHK("tgt", 16'h0210, target_out);
    `CHK("take", 1'b1, take_branch_out);
    // Same taken branch, but the opcode is not marked valid
    @(posedge sys_clk_in);
    #2;
    opcode_valid_in = 1'b0;
    @(posedge sys_clk_in);
    #1;
    `CHK("valid_take", 2'h0, {dec.valid, take_branch_out});
    $display("test branch done");
  endtask

  task automatic t_table();
    logic [7:0] o[8] = '{8'h42, 8'h83, 8'h80, 8'h81, 8'h31, 8'hA7, 8'h9E,
      8'h8C};
    logic [3:0] c[4] = '{4'hB, 4'hA, 4'h9, 4'h6};
    for (int i = 0; i < 8; i++) begin
      step(o[i], 8'h00, 8'h00, 1'b1);
      `CHK("len", 2'h1, dec.len);
      `CHK("unimpl", i > 3, dec.unimpl);
      if (i < 4) begin
        `CHK("cyc", c[i], dec.cycles);
      end else begin
        `CHK("cyc_fx", 9'h000, {dec.cycles, dec.fx});
      end
    end
    step(8'h4D, 8'h00, 8'h00, 1'b0);
    `CHK("cyc", 4'h3, dec.cycles);
    step(8'h3D, 8'h10, 8'h00, 1'b0);
    `CHK("cyc", 4'h4, dec.cycles);
    $display("test table done");
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    sys_clk_in = 1'b0;
    forever #20 sys_clk_in = ~sys_clk_in;
  end

  initial begin
    #40000;
    errors++;
    end_sim();
  end

  initial begin
    {nrst_in, opcode_valid_in, branch_cond_in} = 3'h0;
    {opcode_in, first_byte_in, second_byte_in, index_in} = 32'h0;
    pc_next_in = 16'h0000;
    repeat (20) @(posedge sys_clk_in);
    #2;
    nrst_in = 1'b1;
    t_special();
    t_bits();
    t_modes();
    t_branch();
    t_table();
    end_sim();
  end
endmodule
`default_nettype wire
